// file: hw/srws_window_select.sv
// region-of-interest window selector: register file, region check and pixel crop
//
// Operation
// [R1] coordinates count from column 0, row 0 at the array's upper-left pixel
// [R2] software keeps single width a multiple of 32 and height of 2
// [R3] software keeps single width at least 64 and height at least 4
// [R4] origin moves by the offsets; software keeps size plus offset below limit
// [R5] after reset single width and height sit at maximum; offsets written after size
// [R6] effective array width and height read only; writes do nothing
// [R7] only pixels inside the region are sent, values unchanged
// [R8] sixteen regions, index 0 to 15, chosen by a select index
// [R9] multi mode sends only enabled-region pixels merged into one image
// [R10] all regions share one common width setting
// [R11] each region has an enable bit via the index; disabled regions send nothing
// [R12] each region has column start, row start and height via the index
// [R13] output width is common width; height is sum of enabled heights (here a row shared by enabled regions goes to the lowest index only)
// [R14] software keeps each column start plus common width within array width
// [R15] software keeps each row start plus height within array height
// [R16] software keeps column starts and common width multiples of 32
// [R17] software keeps row starts and heights multiples of 2
// [R18] read-only flag true when multi-region settings meet all constraints (here also false while no region is enabled)
// [R19] read-only status shows whether multi-region mode is in use
// [R20] software should write common width first, then each region
// [R21] multi-region settings can be saved to and restored from a user set
// [R22] regions leave in ascending index; frame first and line last are marked (here regions leave in raster row order)
// [R23] invalid settings are not applied; last valid configuration stays in use
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "srws_regs.svh"

module srws_window_select #(
	parameter logic [15:0] COLS_MAX = 16'd9344,
	parameter logic [15:0] ROWS_MAX = 16'd7000
) (
	input  wire logic                    clk_sys,
	input  wire logic                    resetn,
	input  wire srws_pkg::srws_bus_t     bus,
	output logic [31:0]                  rdata,
	input  wire srws_pkg::srws_pix_in_t  pix_in,
	output srws_pkg::srws_pix_out_t      pix_out,
	output logic                         region_settings_ok,
	output logic                         region_mode_in_use
);

	localparam int NREG = srws_pkg::SRWS_NREG;

	srws_pkg::srws_cfg_t     cfg_sw;
	srws_pkg::srws_cfg_t     next_cfg_sw;
	srws_pkg::srws_cfg_t     cfg_act;
	srws_pkg::srws_cfg_t     next_cfg_act;
	srws_pkg::srws_cfg_t     cfg_user;
	srws_pkg::srws_cfg_t     next_cfg_user;
	logic [3:0]              region_index_sel;
	logic [3:0]              next_region_index_sel;
	logic [31:0]             next_rdata;
	srws_pkg::srws_pix_out_t next_pix_out;
	logic                    first_pending;
	logic                    next_first_pending;
	logic                    next_settings_ok;
	logic                    next_mode_in_use;
	logic                    ok_now;

	// ----------------------------------------------------------------
	// reset image of the configuration
	// ----------------------------------------------------------------
	function automatic srws_pkg::srws_cfg_t cfg_reset();
		srws_pkg::srws_cfg_t c;
		c                    = '0;
		c.crop_cols          = COLS_MAX;                          // R5
		c.crop_rows          = ROWS_MAX;                          // R5
		c.crop_col_start     = `SRWS_RST_START;
		c.crop_row_start     = `SRWS_RST_START;
		c.region_common_cols = `SRWS_RST_REGION_COMMON;
		for (int i = 0; i < NREG; i++) begin
			c.region_col_start[i] = `SRWS_RST_START;
			c.region_row_start[i] = `SRWS_RST_START;
			c.region_rows[i]      = `SRWS_RST_REGION_ROWS;
		end
		return c;
	endfunction : cfg_reset

	// ----------------------------------------------------------------
	// multi-region settings check
	// ----------------------------------------------------------------
	always_comb begin
		logic [16:0] cend;
		logic [16:0] rend;
		logic        any_en;
		ok_now = 1'b1;
		any_en = 1'b0;
		cend   = '0;
		rend   = '0;
		if ((cfg_sw.region_common_cols & `SRWS_COL_ALIGN_MASK) != 16'h0000 ||
			cfg_sw.region_common_cols == 16'h0000) begin
			ok_now = 1'b0;                                            // R16
		end
		// only enabled regions are checked; a disabled one may hold anything
		for (int i = 0; i < NREG; i++) begin
			if (cfg_sw.region_enable[i]) begin
				any_en = 1'b1;
				cend   = {1'b0, cfg_sw.region_col_start[i]} + {1'b0, cfg_sw.region_common_cols};
				rend   = {1'b0, cfg_sw.region_row_start[i]} + {1'b0, cfg_sw.region_rows[i]};
				if (cend > {1'b0, COLS_MAX}) begin
					ok_now = 1'b0;                                    // R14
				end
				if (rend > {1'b0, ROWS_MAX}) begin
					ok_now = 1'b0;                                    // R15
				end
				if ((cfg_sw.region_col_start[i] & `SRWS_COL_ALIGN_MASK) != 16'h0000) begin
					ok_now = 1'b0;                                    // R16
				end
				if ((cfg_sw.region_row_start[i] & `SRWS_ROW_ALIGN_MASK) != 16'h0000 ||
					(cfg_sw.region_rows[i] & `SRWS_ROW_ALIGN_MASK) != 16'h0000 ||
					cfg_sw.region_rows[i] == 16'h0000) begin
					ok_now = 1'b0;                                    // R17
				end
			end
		end
		if (!any_en) begin
			ok_now = 1'b0;                                            // R18
		end
	end

	// ----------------------------------------------------------------
	// settings flag state
	// ----------------------------------------------------------------
	// the flag trails any configuration change by one clock
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			region_settings_ok <= 1'b0;
		end else begin
			region_settings_ok <= next_settings_ok;                        // R18
		end
	end

	// ----------------------------------------------------------------
	// register file
	// ----------------------------------------------------------------
	always_comb begin
		logic [3:0] sel;
		sel                   = region_index_sel;
		next_cfg_sw           = cfg_sw;
		next_cfg_user         = cfg_user;
		next_region_index_sel = region_index_sel;
		next_rdata            = '0;
		if (bus.wr) begin
			unique case (bus.addr)
				`SRWS_OFS_CROP_COLS:      next_cfg_sw.crop_cols      = bus.wdata[15:0];
				`SRWS_OFS_CROP_ROWS:      next_cfg_sw.crop_rows      = bus.wdata[15:0];
				`SRWS_OFS_CROP_COL_START: next_cfg_sw.crop_col_start = bus.wdata[15:0]; // R4
				`SRWS_OFS_CROP_ROW_START: next_cfg_sw.crop_row_start = bus.wdata[15:0]; // R4
				`SRWS_OFS_MODE_CTRL:      next_cfg_sw.multi = bus.wdata[`SRWS_BIT_MODE_MULTI];
				`SRWS_OFS_REGION_SEL:     next_region_index_sel = bus.wdata[3:0];       // R8
				`SRWS_OFS_REGION_ENABLE:  next_cfg_sw.region_enable[sel] = bus.wdata[0]; // R11
				`SRWS_OFS_REGION_COMMON:  next_cfg_sw.region_common_cols = bus.wdata[15:0]; // R10
				`SRWS_OFS_REGION_ROWS:    next_cfg_sw.region_rows[sel] = bus.wdata[15:0];    // R12
				`SRWS_OFS_REGION_COL_ST:  next_cfg_sw.region_col_start[sel] = bus.wdata[15:0]; // R12
				`SRWS_OFS_REGION_ROW_ST:  next_cfg_sw.region_row_start[sel] = bus.wdata[15:0]; // R12
				`SRWS_OFS_USER_SET: begin
					// save takes the multi-region fields; load puts them back
					if (bus.wdata[`SRWS_BIT_USER_SAVE]) begin
						next_cfg_user = cfg_sw;                           // R21
					end else if (bus.wdata[`SRWS_BIT_USER_LOAD]) begin
						next_cfg_sw.region_common_cols = cfg_user.region_common_cols; // R21
						next_cfg_sw.region_enable      = cfg_user.region_enable;
						next_cfg_sw.region_col_start   = cfg_user.region_col_start;
						next_cfg_sw.region_row_start   = cfg_user.region_row_start;
						next_cfg_sw.region_rows        = cfg_user.region_rows;
					end
				end
				default: ;                                                // R6
			endcase
		end
		if (bus.rd) begin
			unique case (bus.addr)
				`SRWS_OFS_ARRAY_COLS:     next_rdata = {16'h0000, COLS_MAX};  // R6
				`SRWS_OFS_ARRAY_ROWS:     next_rdata = {16'h0000, ROWS_MAX};  // R6
				`SRWS_OFS_CROP_COLS_LIM:  next_rdata = {16'h0000, COLS_MAX - cfg_sw.crop_col_start};
				`SRWS_OFS_CROP_ROWS_LIM:  next_rdata = {16'h0000, ROWS_MAX - cfg_sw.crop_row_start};
				`SRWS_OFS_CROP_COLS:      next_rdata = {16'h0000, cfg_sw.crop_cols};
				`SRWS_OFS_CROP_ROWS:      next_rdata = {16'h0000, cfg_sw.crop_rows};
				`SRWS_OFS_CROP_COL_START: next_rdata = {16'h0000, cfg_sw.crop_col_start};
				`SRWS_OFS_CROP_ROW_START: next_rdata = {16'h0000, cfg_sw.crop_row_start};
				`SRWS_OFS_MODE_CTRL:      next_rdata = {31'h0, cfg_sw.multi};
				`SRWS_OFS_REGION_SEL:     next_rdata = {28'h0, region_index_sel};
				`SRWS_OFS_REGION_ENABLE:  next_rdata = {31'h0, cfg_sw.region_enable[sel]};
				`SRWS_OFS_REGION_COMMON:  next_rdata = {16'h0000, cfg_sw.region_common_cols};
				`SRWS_OFS_REGION_ROWS:    next_rdata = {16'h0000, cfg_sw.region_rows[sel]};
				`SRWS_OFS_REGION_COL_ST:  next_rdata = {16'h0000, cfg_sw.region_col_start[sel]};
				`SRWS_OFS_REGION_ROW_ST:  next_rdata = {16'h0000, cfg_sw.region_row_start[sel]};
				`SRWS_OFS_STATUS:         next_rdata = {30'h0, region_mode_in_use, region_settings_ok}; // R18 R19
				default:                  next_rdata = '0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// register file state
	// ----------------------------------------------------------------
	// rdata stands one cycle after a read strobe and is zero otherwise
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cfg_sw           <= cfg_reset();
			cfg_user         <= cfg_reset();
			region_index_sel <= 4'h0;
			rdata            <= 32'h0000_0000;
		end else begin
			cfg_sw           <= next_cfg_sw;
			cfg_user         <= next_cfg_user;
			region_index_sel <= next_region_index_sel;
			rdata            <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// active configuration and pixel crop
	// ----------------------------------------------------------------
	always_comb begin
		srws_pkg::srws_cfg_t use_cfg;
		logic        hit;
		logic        found;
		logic [16:0] col_lo;
		logic [16:0] col_end;
		logic [16:0] r_end;
		logic [16:0] pcol;
		logic [16:0] prow;
		use_cfg          = cfg_act;
		next_cfg_act     = cfg_act;
		next_settings_ok = ok_now;
		next_mode_in_use = region_mode_in_use;
		// settings take effect only at a frame boundary; invalid multi sets are skipped
		if (pix_in.valid && pix_in.sof) begin
			next_cfg_act.multi          = cfg_sw.multi;
			next_cfg_act.crop_cols      = cfg_sw.crop_cols;
			next_cfg_act.crop_rows      = cfg_sw.crop_rows;
			next_cfg_act.crop_col_start = cfg_sw.crop_col_start;
			next_cfg_act.crop_row_start = cfg_sw.crop_row_start;
			if (ok_now) begin
				next_cfg_act.region_common_cols = cfg_sw.region_common_cols; // R23
				next_cfg_act.region_enable      = cfg_sw.region_enable;
				next_cfg_act.region_col_start   = cfg_sw.region_col_start;
				next_cfg_act.region_row_start   = cfg_sw.region_row_start;
				next_cfg_act.region_rows        = cfg_sw.region_rows;
			end
			next_mode_in_use = cfg_sw.multi & (ok_now | (|cfg_act.region_enable)); // R19
		end
		use_cfg = (pix_in.valid && pix_in.sof) ? next_cfg_act : cfg_act;
		pcol    = {1'b0, pix_in.col};                                     // R1
		prow    = {1'b0, pix_in.row};                                     // R1
		hit     = 1'b0;
		found   = 1'b0;
		col_lo  = '0;
		col_end = '0;
		r_end   = '0;
		// pixels carry their own position, so no column or row counter is kept
		if (use_cfg.multi) begin
			// lowest enabled index owning this row wins
			for (int i = 0; i < NREG; i++) begin
				r_end = {1'b0, use_cfg.region_row_start[i]} + {1'b0, use_cfg.region_rows[i]};
				if (!found && use_cfg.region_enable[i] &&                  // R11
					prow >= {1'b0, use_cfg.region_row_start[i]} && prow < r_end) begin
					found   = 1'b1;                                        // R22
					col_lo  = {1'b0, use_cfg.region_col_start[i]};
					col_end = col_lo + {1'b0, use_cfg.region_common_cols}; // R10 R13
				end
			end
			hit = found && pcol >= col_lo && pcol < col_end;               // R9
		end else begin
			col_lo  = {1'b0, use_cfg.crop_col_start};                      // R4
			col_end = col_lo + {1'b0, use_cfg.crop_cols};
			r_end   = {1'b0, use_cfg.crop_row_start} + {1'b0, use_cfg.crop_rows};
			hit     = pcol >= col_lo && pcol < col_end &&
				prow >= {1'b0, use_cfg.crop_row_start} && prow < r_end;    // R7
		end
		hit                      = hit & pix_in.valid;
		next_pix_out.valid       = hit;                                    // R7
		next_pix_out.data        = hit ? pix_in.data : 16'h0000;           // R7
		next_pix_out.frame_first = hit & (first_pending | pix_in.sof);     // R22
		next_pix_out.line_last   = hit & (pcol == col_end - 17'd1);        // R22
		next_first_pending       = (first_pending | (pix_in.valid & pix_in.sof)) & ~hit;
	end

	// ----------------------------------------------------------------
	// pixel path state
	// ----------------------------------------------------------------
	// the active copy moves only at a frame start, so no frame mixes two settings
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			cfg_act            <= cfg_reset();
			pix_out            <= '0;
			first_pending      <= 1'b0;
			region_mode_in_use <= 1'b0;
		end else begin
			cfg_act            <= next_cfg_act;
			pix_out            <= next_pix_out;
			first_pending      <= next_first_pending;
			region_mode_in_use <= next_mode_in_use;                        // R19
		end
	end

endmodule : srws_window_select

`default_nettype wire

// file: inc/srws_pkg.sv
// types shared by the region-of-interest window selector and its users
`default_nettype none
package srws_pkg;

	localparam int SRWS_NREG = 16;

	typedef struct packed {
		logic        valid;
		logic        sof;
		logic [15:0] col;
		logic [15:0] row;
		logic [15:0] data;
	} srws_pix_in_t;

	typedef struct packed {
		logic        valid;
		logic        frame_first;
		logic        line_last;
		logic [15:0] data;
	} srws_pix_out_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} srws_bus_t;

	typedef struct packed {
		logic                        multi;
		logic [15:0]                 crop_cols;
		logic [15:0]                 crop_rows;
		logic [15:0]                 crop_col_start;
		logic [15:0]                 crop_row_start;
		logic [15:0]                 region_common_cols;
		logic [SRWS_NREG-1:0]        region_enable;
		logic [SRWS_NREG-1:0][15:0]  region_col_start;
		logic [SRWS_NREG-1:0][15:0]  region_row_start;
		logic [SRWS_NREG-1:0][15:0]  region_rows;
	} srws_cfg_t;

endpackage : srws_pkg

`default_nettype wire

// file: inc/srws_regs.svh
// register offsets, reset values and limits of the region-of-interest window selector
`ifndef SRWS_REGS_SVH
`define SRWS_REGS_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define SRWS_OFS_ARRAY_COLS      8'h00
`define SRWS_OFS_ARRAY_ROWS      8'h04
`define SRWS_OFS_CROP_COLS_LIM   8'h08
`define SRWS_OFS_CROP_ROWS_LIM   8'h0C
`define SRWS_OFS_CROP_COLS       8'h10
`define SRWS_OFS_CROP_ROWS       8'h14
`define SRWS_OFS_CROP_COL_START  8'h18
`define SRWS_OFS_CROP_ROW_START  8'h1C
`define SRWS_OFS_MODE_CTRL       8'h20
`define SRWS_OFS_REGION_SEL      8'h24
`define SRWS_OFS_REGION_ENABLE   8'h28
`define SRWS_OFS_REGION_COMMON   8'h2C
`define SRWS_OFS_REGION_ROWS     8'h30
`define SRWS_OFS_REGION_COL_ST   8'h34
`define SRWS_OFS_REGION_ROW_ST   8'h38
`define SRWS_OFS_STATUS          8'h3C
`define SRWS_OFS_USER_SET        8'h40

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SRWS_BIT_MODE_MULTI      0
`define SRWS_BIT_STAT_OK         0
`define SRWS_BIT_STAT_IN_USE     1
`define SRWS_BIT_USER_SAVE       0
`define SRWS_BIT_USER_LOAD       1

// ----------------------------------------------------------------
// reset values and alignment
// ----------------------------------------------------------------
`define SRWS_RST_START           16'h0000
`define SRWS_RST_REGION_COMMON   16'h0040
`define SRWS_RST_REGION_ROWS     16'h0004
`define SRWS_COL_ALIGN_MASK      16'h001F
`define SRWS_ROW_ALIGN_MASK      16'h0001

`endif

// file: verification/srws_sensor_model.sv
// behavioural sensor readout streaming full raster frames on request
`timescale 1ns/100ps
`default_nettype none

module srws_sensor_model #(
	parameter logic [15:0] COLS = 16'h0080,
	parameter logic [15:0] ROWS = 16'h0008
) (
	input  wire logic              clk_sys,
	input  wire logic              start,
	output srws_pkg::srws_pix_in_t pix,
	output logic                   busy
);
	// one pixel a clock; data carries its own row and column
	initial begin
		pix = '0;
		busy = 1'b0;
		forever begin
			@(posedge clk_sys);
			if (start === 1'b1) begin
				busy <= 1'b1;
				for (logic [15:0] r = 16'h0000; r < ROWS; r++) begin
					for (logic [15:0] c = 16'h0000; c < COLS; c++) begin
						pix <= '{valid: 1'b1, sof: (r == 16'h0000 && c == 16'h0000),
							col: c, row: r, data: {r[7:0], c[7:0]}};
						@(posedge clk_sys);
					end
				end
				// between frames the lines no longer hold the last pixel
				pix <= '{valid: 1'b0, sof: 1'b0, col: ~pix.col, row: ~pix.row, data: ~pix.data};
				busy <= 1'b0;
			end
		end
	end
endmodule : srws_sensor_model

`default_nettype wire

// file: verification/srws_window_select_monitor.sv
// port assertions of the region-of-interest window selector
`timescale 1ns/100ps
`default_nettype none

module srws_window_select_monitor #(
	parameter logic [15:0] COLS_MAX = 16'h2480,
	parameter logic [15:0] ROWS_MAX = 16'h1B58
) (
	input wire logic                    clk_sys,
	input wire logic                    resetn,
	input wire srws_pkg::srws_bus_t     bus,
	input wire logic [31:0]             rdata,
	input wire srws_pkg::srws_pix_in_t  pix_in,
	input wire srws_pkg::srws_pix_out_t pix_out,
	input wire logic                    region_settings_ok,
	input wire logic                    region_mode_in_use
);
	default clocking mon_cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	ro_cols_read_a: assert property (bus.rd && bus.addr == 8'h00 |=> rdata == {16'h0000, COLS_MAX})
		else $error("array width read wrong");
	ro_rows_read_a: assert property (bus.rd && bus.addr == 8'h04 |=> rdata == {16'h0000, ROWS_MAX})
		else $error("array height read wrong");
	pixel_source_a: assert property (pix_out.valid |-> $past(pix_in.valid) && pix_out.data == $past(pix_in.data))
		else $error("output pixel not taken from input");
	out_quiet_a: assert property (!pix_out.valid |-> pix_out.data == 16'h0000 && !pix_out.frame_first && !pix_out.line_last)
		else $error("marks or data without valid pixel");
	status_read_a: assert property (bus.rd && bus.addr == 8'h3C |=> rdata[1:0] == {$past(region_mode_in_use), $past(region_settings_ok)})
		else $error("status read differs from flags");
	ok_timing_a: assert property ($changed(region_settings_ok) |-> $past(bus.wr) || $past(bus.wr, 2))
		else $error("settings flag moved without a write");
	in_use_sof_a: assert property ($changed(region_mode_in_use) |-> $past(pix_in.valid && pix_in.sof))
		else $error("mode status moved outside frame start");
	in_use_ok_a: assert property ($rose(region_mode_in_use) |-> $past(region_settings_ok))
		else $error("multi mode entered with invalid settings");
endmodule : srws_window_select_monitor

bind srws_window_select srws_window_select_monitor #(
	.COLS_MAX(COLS_MAX),
	.ROWS_MAX(ROWS_MAX)
) srws_window_select_monitor_inst (
	.clk_sys(clk_sys),
	.resetn(resetn),
	.bus(bus),
	.rdata(rdata),
	.pix_in(pix_in),
	.pix_out(pix_out),
	.region_settings_ok(region_settings_ok),
	.region_mode_in_use(region_mode_in_use)
);

`default_nettype wire

// file: verification/srws_window_select_tb.sv
// self-checking bench of the region-of-interest window selector
`timescale 1ns/100ps
`default_nettype none

module srws_window_select_tb;
	localparam logic [15:0] COLS = 16'h0080;
	localparam logic [15:0] ROWS = 16'h0008;
	logic                    clk_sys = 1'b0;
	logic                    resetn = 1'b0;
	logic                    start = 1'b0;
	logic                    busy;
	srws_pkg::srws_bus_t     bus = '0;
	logic [31:0]             rdata;
	srws_pkg::srws_pix_in_t  pix_in;
	srws_pkg::srws_pix_out_t pix_out;
	logic                    ok;
	logic                    in_use;
	int                      err_total = 0;
	int                      checks = 0;
	int                      n_out = 0;
	logic                    m = 1'b0;
	logic [15:0]             cs, rs, w, h, cw;
	logic [15:0]             en = '0;
	logic [15:0]             rcs [16];
	logic [15:0]             rrs [16];
	logic [15:0]             rh [16];
	logic [1:0]              px_e;

	always #2 clk_sys = ~clk_sys;

	srws_window_select #(.COLS_MAX(COLS), .ROWS_MAX(ROWS)) srws_window_select_inst (
		.clk_sys(clk_sys), .resetn(resetn), .bus(bus), .rdata(rdata), .pix_in(pix_in),
		.pix_out(pix_out), .region_settings_ok(ok), .region_mode_in_use(in_use));
	srws_sensor_model #(.COLS(COLS), .ROWS(ROWS)) srws_sensor_model_inst (
		.clk_sys(clk_sys), .start(start), .pix(pix_in), .busy(busy));

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys);
		bus <= '0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string name);
		@(posedge clk_sys);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
		@(posedge clk_sys);
		bus <= '0;
		@(negedge clk_sys);
		chk(name, rdata, e);
	endtask : rd

	task automatic set_region(input int k, input logic e, input logic [15:0] c0, r0, nr);
		wr(8'h24, 32'(k));
		wr(8'h28, {31'h0, e});
		wr(8'h30, {16'h0, nr});
		wr(8'h34, {16'h0, c0});
		wr(8'h38, {16'h0, r0});
		en[k] = e;
		rcs[k] = c0;
		rrs[k] = r0;
		rh[k] = nr;
	endtask : set_region

	// expected {kept, last of line}; lowest enabled index covering the pixel wins
	function automatic logic [1:0] expect_px(input logic [15:0] r, c);
		logic [1:0] res;
		res = 2'b00;
		if (!m && c >= cs && c < cs + w && r >= rs && r < rs + h)
			res = {1'b1, c == cs + w - 16'h1};
		for (int k = 15; k >= 0; k--)
			if (m && en[k] && r >= rrs[k] && r < rrs[k] + rh[k] && c >= rcs[k] && c < rcs[k] + cw)
				res = {1'b1, c == rcs[k] + cw - 16'h1};
		return res;
	endfunction : expect_px

	always @(negedge clk_sys) begin
		if (resetn && pix_out.valid === 1'b1) begin
			px_e = expect_px({8'h0, pix_out.data[15:8]}, {8'h0, pix_out.data[7:0]});
			chk("pixel inside region", {31'h0, px_e[1]}, 32'h1);
			chk("line last mark", {31'h0, pix_out.line_last}, {31'h0, px_e[0]});
			chk("frame first mark", {31'h0, pix_out.frame_first}, {31'h0, n_out == 0});
			n_out++;
		end
	end

	task automatic run_frame(input int exp_n);
		n_out = 0;
		@(posedge clk_sys);
		start <= 1'b1;
		@(posedge clk_sys);
		start <= 1'b0;
		@(negedge clk_sys);
		for (int i = 0; busy !== 1'b0; i++) begin
			if (i > 4000) begin
				err_total++;
				report_and_stop();
			end
			@(posedge clk_sys);
		end
		repeat (3) @(posedge clk_sys);
		chk("kept pixel count", 32'(n_out), 32'(exp_n));
	endtask : run_frame

	initial begin
		rcs = '{default: 16'h0};
		rrs = '{default: 16'h0};
		rh = '{default: 16'h0};
		repeat (6) @(posedge clk_sys);
		resetn <= 1'b1;
		rd(8'h00, {16'h0, COLS}, "array cols");
		rd(8'h04, {16'h0, ROWS}, "array rows");
		rd(8'h10, {16'h0, COLS}, "crop cols reset");
		rd(8'h14, {16'h0, ROWS}, "crop rows reset");
		wr(8'h00, 32'h0000_0020);
		rd(8'h00, {16'h0, COLS}, "array cols after write");
		rd(8'h44, 32'h0, "unmapped read");
		chk("settings ok after reset", {31'h0, ok}, 32'h0);
		// single window: size first, then offsets
		{cs, rs, w, h} = {16'h0020, 16'h0002, 16'h0040, 16'h0004};
		wr(8'h10, 32'h40);
		wr(8'h14, 32'h4);
		wr(8'h18, 32'h20);
		wr(8'h1C, 32'h2);
		rd(8'h08, 32'h60, "crop col limit");
		rd(8'h0C, 32'h6, "crop row limit");
		run_frame(256);
		// multi window: common width first, then each region
		cw = 16'h0040;
		wr(8'h2C, 32'h40);
		set_region(15, 1'b0, 16'h0, 16'h0, 16'h6);
		rd(8'h30, 32'h6, "region 15 rows");
		set_region(1, 1'b1, 16'h0, 16'h0, 16'h2);
		set_region(2, 1'b0, 16'h20, 16'h2, 16'h2);
		set_region(3, 1'b1, 16'h40, 16'h4, 16'h4);
		wr(8'h20, 32'h1);
		m = 1'b1;
		rd(8'h20, 32'h1, "mode multi");
		rd(8'h24, 32'h3, "region index");
		rd(8'h3C, 32'h1, "status before frame");
		run_frame(384);
		rd(8'h3C, 32'h3, "status multi");
		// invalid width keeps the previous set in use
		wr(8'h2C, 32'h30);
		rd(8'h3C, 32'h2, "status invalid");
		run_frame(384);
		wr(8'h2C, 32'h40);
		wr(8'h34, 32'h60);
		rd(8'h3C, 32'h2, "status col overflow");
		wr(8'h34, 32'h10);
		rd(8'h3C, 32'h2, "status col misaligned");
		wr(8'h34, 32'h40);
		wr(8'h38, 32'h6);
		rd(8'h3C, 32'h2, "status row overflow");
		wr(8'h38, 32'h3);
		rd(8'h3C, 32'h2, "status odd row start");
		wr(8'h38, 32'h4);
		rd(8'h3C, 32'h3, "status valid again");
		wr(8'h40, 32'h1);
		wr(8'h28, 32'h0);
		wr(8'h34, 32'h0);
		rd(8'h28, 32'h0, "enable cleared");
		wr(8'h40, 32'h2);
		rd(8'h28, 32'h1, "enable restored");
		rd(8'h34, 32'h40, "col start restored");
		run_frame(384);
		wr(8'h20, 32'h0);
		m = 1'b0;
		run_frame(256);
		chk("mode in use off", {31'h0, in_use}, 32'h0);
		report_and_stop();
	end
endmodule : srws_window_select_tb

`default_nettype wire
